// ===== shared/ssp_pkg.sv
// constants, types and helpers for the switching sync and phase control
// assumes one 250 MHz clock shared by every user of this package
package ssp_pkg;

	localparam int unsigned CLK_PERIOD_NS  = 4;
	localparam int unsigned CLK_KHZ        = 250000;

	localparam int unsigned CFG_W          = 32;
	localparam logic [31:0] CFG_RESET      = 32'h0000_0000;

	localparam int unsigned A_SEL_BIT      = 5;
	localparam int unsigned B_SEL_BIT      = 6;
	localparam int unsigned A_INT_BIT      = 8;
	localparam int unsigned B_INT_BIT      = 9;
	localparam int unsigned A_EXT_BIT      = 14;
	localparam int unsigned B_EXT_BIT      = 15;
	localparam int unsigned A_PH_LSB       = 20;
	localparam int unsigned B_PH_LSB       = 28;
	localparam int unsigned PH_W           = 4;
	localparam logic [3:0]  PH_MAX_CODE    = 4'hb;
	localparam int unsigned PH_STEP_DEG    = 30;
	localparam int unsigned PH_STEPS       = 360 / PH_STEP_DEG;

	localparam int unsigned SYNC_MIN_PW_NS = 100;
	localparam int unsigned SYNC_MIN_CYC   = (SYNC_MIN_PW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// two synchroniser stages plus the filter register
	localparam int unsigned SYNC_LAT       = SYNC_MIN_CYC + 3;

	localparam int unsigned SW_MIN_KHZ     = 300;
	localparam int unsigned SW_MAX_KHZ     = 2000;
	localparam int unsigned AGG_MAX_KHZ    = 8000;
	localparam int unsigned PER_W          = 16;
	localparam int unsigned PER_MAX        = CLK_KHZ / SW_MIN_KHZ;
	localparam int unsigned PER_MIN        = (CLK_KHZ + SW_MAX_KHZ - 1) / SW_MAX_KHZ;
	localparam int unsigned NPH_W          = 3;

	typedef enum logic [1:0] {
		SSP_DIS = 2'b00,
		SSP_INT = 2'b01,
		SSP_EXT = 2'b10
	} ssp_mode_e;

	typedef struct packed {
		ssp_mode_e  mode;
		logic [3:0] code;
	} ssp_chan_s;

	// unlisted bit combinations fall back to disabled
	function automatic ssp_mode_e ssp_decode(input logic sel, input logic int_b,
		input logic ext_b);
		ssp_mode_e m;
		m = SSP_DIS;
		if (!sel && int_b && !ext_b) begin
			m = SSP_INT;
		end else if (sel && !int_b && ext_b) begin
			m = SSP_EXT;
		end
		return m;
	endfunction

	// least period in cycles so that fsw times phases stays within the aggregate rate
	function automatic logic [15:0] ssp_min_period(input logic [2:0] n);
		int unsigned t;
		t = (32'(n) * CLK_KHZ + AGG_MAX_KHZ - 1) / AGG_MAX_KHZ;
		return t[15:0];
	endfunction

endpackage

// ===== rtl/ssp_phase_gen.sv
// one channel phase tap: pulses when the reference count meets the offset
// assumes cnt_in and period_in come from logic on clk_in
`timescale 1ns/1ps
`default_nettype none
module ssp_phase_gen
	import ssp_pkg::*;
#(
	parameter int unsigned W = PER_W
) (
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	input  wire logic [W-1:0] cnt_in,
	input  wire logic [W-1:0] period_in,
	input  wire ssp_chan_s    chan_in,
	output logic              pulse_out
);

	typedef struct packed {
		logic [W-1:0] off;
		logic         pulse;
	} ssp_ph_st_s;

	ssp_ph_st_s   st_q;
	ssp_ph_st_s   st_d;
	logic [3:0]   code;
	logic [W+3:0] prod;

	always_comb begin
		st_d = st_q;
		code = (chan_in.code > PH_MAX_CODE) ? PH_MAX_CODE : chan_in.code;
		// no reference to align to when disabled
		if (chan_in.mode == SSP_DIS) begin
			code = 4'h0;
		end
		prod = period_in * code;
		st_d.off = W'(prod / (W+4)'(PH_STEPS));
		st_d.pulse = (cnt_in == st_q.off);
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign pulse_out = st_q.pulse;

	a_phase_tap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		pulse_out |-> $past(cnt_in) == $past(st_q.off))
		else $error("phase pulse not at programmed offset");

endmodule // ssp_phase_gen
`default_nettype wire

// ===== rtl/ssp_ctrl.sv
// sync mode select, reference counter, sync pin and two phase taps
// assumes sw_period_in and active_phases_in come from logic on clk_in
//
// Operation
// - channel a mode from bits 5, 8, 14
// - channel b mode from bits 6, 9, 15
// - channel a offset bits 23:20, 30 degree steps
// - channel b offset bits 31:28, 30 degree steps
// - driven sync output near 50 percent duty
`timescale 1ns/1ps
`default_nettype none
module ssp_ctrl
	import ssp_pkg::*;
(
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             cfg_wr_in,
	input  wire logic [CFG_W-1:0] cfg_wdata_in,
	output logic      [CFG_W-1:0] cfg_rdata_out,
	input  wire logic [PER_W-1:0] sw_period_in,
	input  wire logic [NPH_W-1:0] active_phases_in,
	input  wire logic             sync_in,
	output logic                  sync_out,
	output logic                  sync_oe_n_out,
	output logic                  chan_a_clk_out,
	output logic                  chan_b_clk_out,
	output ssp_mode_e             chan_a_mode_out,
	output ssp_mode_e             chan_b_mode_out,
	output logic                  rate_clamped_out,
	output logic                  ext_edge_out
);

	localparam logic [5:0]       HI_TGT  = 6'(SYNC_MIN_CYC);
	localparam logic [PER_W-1:0] P_MIN   = PER_W'(PER_MIN);
	localparam logic [PER_W-1:0] P_MAX   = PER_W'(PER_MAX);
	localparam logic [PER_W-1:0] P_ALIGN = PER_W'(SYNC_LAT);

	typedef struct packed {
		logic [CFG_W-1:0] cfg;
		logic             sync_m;
		logic             sync_s;
		logic [5:0]       hi_cnt;
		logic             ext_evt;
		logic [PER_W-1:0] ref_cnt;
		logic [PER_W-1:0] eff_per;
		logic             clamped;
		ssp_mode_e        mode_a;
		ssp_mode_e        mode_b;
		logic             sync_o;
		logic             oe_n;
	} ssp_st_s;

	ssp_st_s          st_q;
	ssp_st_s          st_d;
	logic [PER_W-1:0] per;
	logic [PER_W-1:0] per_lim;
	logic             any_ext;
	logic             any_int;
	ssp_chan_s        chan_a;
	ssp_chan_s        chan_b;

	always_comb begin
		st_d = st_q;
		if (cfg_wr_in) begin
			st_d.cfg = cfg_wdata_in;
		end
		st_d.mode_a = ssp_decode(st_q.cfg[A_SEL_BIT], st_q.cfg[A_INT_BIT],
			st_q.cfg[A_EXT_BIT]);
		st_d.mode_b = ssp_decode(st_q.cfg[B_SEL_BIT], st_q.cfg[B_INT_BIT],
			st_q.cfg[B_EXT_BIT]);

		// out-of-range programming is held to the supported band
		per = sw_period_in;
		if (per < P_MIN) begin
			per = P_MIN;
		end else if (per > P_MAX) begin
			per = P_MAX;
		end
		per_lim = ssp_min_period(active_phases_in);
		st_d.clamped = 1'b0;
		if (per < per_lim) begin
			per = per_lim;
			st_d.clamped = 1'b1;
		end
		st_d.eff_per = per;

		// first stage feeds only the second
		st_d.sync_m = sync_in;
		st_d.sync_s = st_q.sync_m;
		// shorter pulses never reach the count, so glitches are dropped
		if (!st_q.sync_s) begin
			st_d.hi_cnt = 6'h00;
		end else if (st_q.hi_cnt != HI_TGT) begin
			st_d.hi_cnt = st_q.hi_cnt + 6'h01;
		end
		st_d.ext_evt = st_q.sync_s && (st_q.hi_cnt == HI_TGT - 6'h01);

		any_ext = (st_q.mode_a == SSP_EXT) || (st_q.mode_b == SSP_EXT);
		any_int = (st_q.mode_a == SSP_INT) || (st_q.mode_b == SSP_INT);
		// edge seen late by the filter, so the count is preloaded with that lag
		if (any_ext && st_q.ext_evt) begin
			st_d.ref_cnt = P_ALIGN;
		end else if (st_q.ref_cnt >= st_q.eff_per - 16'h0001) begin
			st_d.ref_cnt = 16'h0000;
		end else begin
			st_d.ref_cnt = st_q.ref_cnt + 16'h0001;
		end
		// no frequency check of the external clock; a far-off source just re-aligns each edge
		st_d.sync_o = st_q.ref_cnt < (st_q.eff_per >> 1);
		// never drive the pin while listening to it
		st_d.oe_n = !(any_int && !any_ext);
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st_q <= '0;
			st_q.cfg <= CFG_RESET;
			st_q.oe_n <= 1'b1;
			st_q.eff_per <= P_MAX;
		end else begin
			st_q <= st_d;
		end
	end

	assign chan_a.mode = st_q.mode_a;
	assign chan_a.code = st_q.cfg[A_PH_LSB +: PH_W];
	assign chan_b.mode = st_q.mode_b;
	assign chan_b.code = st_q.cfg[B_PH_LSB +: PH_W];

	ssp_phase_gen #(.W(PER_W)) u_ph_a (
		.clk_in    (clk_in),
		.rst_n_in  (rst_n_in),
		.cnt_in    (st_q.ref_cnt),
		.period_in (st_q.eff_per),
		.chan_in   (chan_a),
		.pulse_out (chan_a_clk_out)
	);

	ssp_phase_gen #(.W(PER_W)) u_ph_b (
		.clk_in    (clk_in),
		.rst_n_in  (rst_n_in),
		.cnt_in    (st_q.ref_cnt),
		.period_in (st_q.eff_per),
		.chan_in   (chan_b),
		.pulse_out (chan_b_clk_out)
	);

	assign cfg_rdata_out    = st_q.cfg;
	assign sync_out         = st_q.sync_o;
	assign sync_oe_n_out    = st_q.oe_n;
	assign chan_a_mode_out  = st_q.mode_a;
	assign chan_b_mode_out  = st_q.mode_b;
	assign rate_clamped_out = st_q.clamped;
	assign ext_edge_out     = st_q.ext_evt;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	a_mode_a_ext: assert property (
		cfg_wr_in && cfg_wdata_in[A_SEL_BIT] && !cfg_wdata_in[A_INT_BIT]
		&& cfg_wdata_in[A_EXT_BIT] |-> ##2 chan_a_mode_out == SSP_EXT)
		else $error("channel a not external after select");
	a_mode_a_dis: assert property (
		cfg_wr_in && !cfg_wdata_in[A_INT_BIT] && !cfg_wdata_in[A_EXT_BIT]
		|-> ##2 chan_a_mode_out == SSP_DIS)
		else $error("channel a not disabled");
	a_mode_b_int: assert property (
		cfg_wr_in && !cfg_wdata_in[B_SEL_BIT] && cfg_wdata_in[B_INT_BIT]
		&& !cfg_wdata_in[B_EXT_BIT] |-> ##2 chan_b_mode_out == SSP_INT)
		else $error("channel b not internal after select");
	a_ext_align: assert property (
		ext_edge_out && ((chan_a_mode_out == SSP_EXT) || (chan_b_mode_out == SSP_EXT))
		|=> st_q.ref_cnt == P_ALIGN)
		else $error("reference not aligned to external edge");
	a_sync_duty: assert property (
		!sync_oe_n_out && $stable(st_q.eff_per) && (st_q.ref_cnt == 16'h0001)
		|-> sync_out)
		else $error("sync output low at period start");
	a_sync_drop: assert property (
		// a period change mid-cycle may drop the level anywhere, so only steady periods count
		$fell(sync_out) && ($past(st_q.eff_per, 1) == $past(st_q.eff_per, 2))
		|-> $past(st_q.ref_cnt, 1) == ($past(st_q.eff_per, 1) >> 1))
		else $error("sync output falls away from half period");
	a_pulse_width: assert property (
		ext_edge_out |-> $past(st_q.sync_s, 1) && $past(st_q.sync_s, 12)
		&& $past(st_q.sync_s, 25))
		else $error("edge taken from short sync pulse");
	a_rate_limit: assert property (
		st_q.eff_per >= ssp_min_period($past(active_phases_in)))
		else $error("period above aggregate rate");
	a_pin_dir: assert property (
		!sync_oe_n_out |-> $past(chan_a_mode_out != SSP_EXT && chan_b_mode_out != SSP_EXT))
		else $error("pin driven in external mode");

	c_ext_lock:  cover property (ext_edge_out && chan_a_mode_out == SSP_EXT);
	c_driving:   cover property (!sync_oe_n_out ##1 $fell(sync_out));
	c_clamped:   cover property (rate_clamped_out);
	c_b_tap:     cover property (chan_b_clk_out && st_q.cfg[B_PH_LSB +: PH_W] == PH_MAX_CODE);

endmodule // ssp_ctrl
`default_nettype wire

// ===== verif/ssp_sync_src.sv
// far-side sync source: one high pulse per request, then low for the rest of the period
// assumes go_in is driven on clk_in rising edges by the bench
`timescale 1ns/1ps
`default_nettype none
module ssp_sync_src (
	input  wire logic        clk_in,
	input  wire logic        go_in,
	input  wire logic [15:0] high_in,
	input  wire logic [15:0] period_in,
	output logic             sync_line_out,
	output logic             busy_out
);
	logic [15:0] cnt_q;
	initial cnt_q = 16'h0000;
	always @(posedge clk_in) begin
		if (cnt_q != 16'h0000) begin
			cnt_q <= cnt_q - 16'h0001;
		end else if (go_in) begin
			cnt_q <= period_in;
		end
	end
	// line rests low between pulses; short pulses only when the bench probes refusal
	assign sync_line_out = (cnt_q > period_in - high_in);
	// next pulse waits a whole programmed period, so back-to-back requests repeat every period plus one cycle
	assign busy_out = (cnt_q != 16'h0000);
endmodule // ssp_sync_src
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the sync mode, phase offset and rate clamp logic
// assumes ssp_pkg and the sync source model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ssp_pkg::*;
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        wr = 1'b0;
	logic        go = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [15:0] per = 16'h00f0;
	logic [15:0] hi = 16'h0000;
	logic [2:0]  nph = 3'h1;
	logic [31:0] rdata;
	logic        so, oe_n, ca, cb, clamp, edge_p, src_line, busy, wr_d1, wr_d2;
	ssp_mode_e   ma, mb;
	wire         pin;
	logic [31:0] q_cfg[$];
	logic [3:0]  q_mode[$];
	logic [31:0] ta[4] = '{32'h0000_0000, 32'h0000_0100, 32'h0000_4020, 32'h0000_0120};
	logic [31:0] tb_m[4] = '{32'h0000_0000, 32'h0000_0200, 32'h0000_8040, 32'h0000_0240};
	int          n_fail = 0;
	int          n_checks = 0;
	int          cyc = 0;
	always #2 clk_in = ~clk_in;
	// pin level: device wins while its enable is low
	assign pin = oe_n ? src_line : so;
	ssp_ctrl ssp_ctrl_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .cfg_wr_in(wr),
		.cfg_wdata_in(wdata), .cfg_rdata_out(rdata), .sw_period_in(per),
		.active_phases_in(nph), .sync_in(pin), .sync_out(so), .sync_oe_n_out(oe_n),
		.chan_a_clk_out(ca), .chan_b_clk_out(cb), .chan_a_mode_out(ma),
		.chan_b_mode_out(mb), .rate_clamped_out(clamp), .ext_edge_out(edge_p));
	ssp_sync_src ssp_sync_src_i (.clk_in(clk_in), .go_in(go), .high_in(hi),
		.period_in(per), .sync_line_out(src_line), .busy_out(busy));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	function automatic logic [1:0] emode(input logic s, input logic i, input logic e);
		return (!s && i && !e) ? 2'h1 : ((s && !i && e) ? 2'h2 : 2'h0);
	endfunction
	task automatic cfg(input logic [31:0] w);
		wr <= 1'b1;
		wdata <= w;
		q_cfg.push_back(w);
		q_mode.push_back({emode(w[5], w[8], w[14]), emode(w[6], w[9], w[15])});
		@(posedge clk_in);
	endtask
	// one sync period from rise to rise: length, high count, first pulse of each channel
	task automatic probe(output int p, output int h, output int a, output int b);
		int   k;
		logic pv;
		k = 0;
		while (so !== 1'b0 && k < 2000) begin
			@(posedge clk_in);
			k++;
		end
		while (so !== 1'b1 && k < 2000) begin
			@(posedge clk_in);
			k++;
		end
		p = 0;
		h = 0;
		a = -1;
		b = -1;
		do begin
			if (so === 1'b1) h++;
			if (ca === 1'b1 && a < 0) a = p;
			if (cb === 1'b1 && b < 0) b = p;
			p++;
			pv = so;
			@(posedge clk_in);
		end while (!(pv === 1'b0 && so === 1'b1) && p < 2000);
	endtask
	// result watcher: readback one cycle, modes two cycles after the taking edge
	always @(posedge clk_in) begin
		wr_d1 <= wr;
		wr_d2 <= wr_d1;
		if (wr_d1) chk(rdata, q_cfg.pop_front(), "readback");
		if (wr_d2) chk({28'h000_0000, ma, mb}, {28'h000_0000, q_mode.pop_front()}, "modes");
		cyc++;
		if (cyc > 20000) begin
			n_fail++;
			final_report();
		end
	end
	initial begin
		int p, h, a, b, n, e;
		void'($urandom(56439));
		repeat (5) @(posedge clk_in);
		chk(rdata, 32'h0000_0000, "reset cfg");
		chk({28'h000_0000, oe_n, so, clamp, edge_p}, 32'h0000_0008, "reset outs");
		rst_n_in <= 1'b1;
		@(posedge clk_in);
		for (int i = 0; i < 16; i++) cfg(($urandom() & 32'hffff_3c9f) | ta[i % 4] | tb_m[i / 4]);
		wr <= 1'b0;
		$display("test modes done");
		nph <= 3'h2;
		for (int c = 0; c <= 12; c++) begin
			cfg({4'(12 - c), 4'h0, 4'(c), 20'h0_0300});
			wr <= 1'b0;
			repeat (4) @(posedge clk_in);
			probe(p, h, a, b);
			chk(p, 240, "period");
			chk(h, 120, "duty");
			chk(a, (c > 11 ? 11 : c) * 20, "phase a");
			chk(b, (12 - c > 11 ? 11 : 12 - c) * 20, "phase b");
			chk(oe_n, 1'b0, "drive enable");
		end
		$display("test phase done");
		cfg(32'h0060_0100);
		wr <= 1'b0;
		per <= 16'h007d;
		for (int j = 0; j < 2; j++) begin
			nph <= (j == 0) ? 3'h7 : 3'h1;
			e = (j == 0) ? 219 : 125;
			repeat (4) @(posedge clk_in);
			probe(p, h, a, b);
			chk(p, e, "clamped period");
			chk(a, e * 6 / 12, "clamped phase");
			chk(clamp, (j == 0) ? 1'b1 : 1'b0, "clamp flag");
		end
		$display("test clamp done");
		per <= 16'h00f0;
		cfg(32'h0000_4020);
		wr <= 1'b0;
		repeat (4) @(posedge clk_in);
		chk(oe_n, 1'b1, "pin released");
		for (int j = 0; j < 3; j++) begin
			hi <= (j == 0) ? 16'h0018 : ((j == 1) ? 16'h0019 : 16'h003c);
			go <= 1'b1;
			@(posedge clk_in);
			go <= 1'b0;
			n = 0;
			repeat (260) begin
				@(posedge clk_in);
				if (edge_p === 1'b1) n++;
			end
			chk(n, (j == 0) ? 0 : 1, "sync edges");
		end
		$display("test external sync done");
		final_report();
	end
endmodule // tb
`default_nettype wire
